//--- src/rcss_pkg.sv
// constants, types and register map of the reset cause and start-up sequencer
package rcss_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_PCL    = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_POWER_CONTROL_FLAGS   = 8'h8e;

  // status layout: [7:5] upper, [4] timeout_flag_n, [3] powerdown_flag_n, [2:0] reset-independent
  localparam int TO_BIT = 4;
  localparam int PD_BIT = 3;
  localparam int LSF_BIT = 0;

  localparam logic [4:0] ST_UP_POR      = 5'h03;
  localparam logic [4:0] ST_UP_MASTER_CLEAR_PIN_N_RUN = 5'h03;
  localparam logic [4:0] ST_UP_MASTER_CLEAR_PIN_N_SLP = 5'h02;
  localparam logic [4:0] ST_UP_WDT      = 5'h01;
  localparam logic [2:0] ST_LOW_RST     = 3'h0;
  localparam logic [1:0] POWER_CONTROL_FLAGS_HI_POR    = 2'h0;
  localparam logic       LSF_RST        = 1'b0;
  localparam logic [7:0] PC_RESET       = 8'h00;
  localparam logic [7:0] PC_VECTOR      = 8'h04;
  localparam logic [7:0] PC_STEP        = 8'h01;
  localparam logic [7:0] RDATA_NONE     = 8'h00;

  // oscillator select: 0 crystal, 1 internal (default)
  localparam logic OSC_XTAL = 1'b0;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int POWER_UP_DELAY_TIMER_MS       = 72;
  localparam int LFOSC_KHZ     = 32;
  localparam int POWER_UP_DELAY_TIMER_TICKS    = POWER_UP_DELAY_TIMER_MS * LFOSC_KHZ;
  localparam int OST_CYC       = 1024;
  localparam int IN_DELAY_CYC  = 8;
  localparam int MASTER_CLEAR_PIN_N_FILT_NS  = 100;
  localparam int MASTER_CLEAR_PIN_N_FILT_CYC = (MASTER_CLEAR_PIN_N_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] POWER_UP_DELAY_TIMER_LAST = CNT_W'(POWER_UP_DELAY_TIMER_TICKS - 1);
  localparam logic [CNT_W-1:0] OST_LAST  = CNT_W'(OST_CYC - 1);
  localparam logic [CNT_W-1:0] IN_LAST   = CNT_W'(IN_DELAY_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 12'h001;

  localparam int FILT_W = 5;
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(MASTER_CLEAR_PIN_N_FILT_CYC - 1);
  localparam logic [FILT_W-1:0] FILT_ZERO = 5'h00;
  localparam logic [FILT_W-1:0] FILT_ONE  = 5'h01;

  // -----------------------------------------------------------------
  // synchroniser lanes
  // -----------------------------------------------------------------
  localparam int SYNC_N  = 5;
  localparam int SI_POR  = 0;
  localparam int SI_MASTER_CLEAR_PIN_N = 1;
  localparam int SI_LSV  = 2;
  localparam int SI_LF   = 3;
  localparam int SI_OSC  = 4;
  // power-on lane starts asserted, pin lane starts idle high
  localparam logic [SYNC_N-1:0] SYNC_RST = 5'h03;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_POR, SEQ_POWER_UP_DELAY_TIMER, SEQ_SETTLE, SEQ_RUN} rcss_seq_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rcss_bus_req_t;

  typedef struct packed {
    logic power_up_delay_enable_n;
    logic osc_select_bit;
  } rcss_cfg_t;

endpackage

//--- src/rcss_top.sv
// reset cause recording and start-up sequencing with its registers
//
// Implementation choice: the address-and-strobe port.

module rcss_top (
  input  logic                   clk_sys,
  input  logic                   rst_n,
  input  logic                   por_pulse,
  input  logic                   master_clear_pin_n,
  input  logic                   low_supply_trip,
  input  logic                   lfosc_clk_in,
  input  logic                   osc_input_pin,
  input  logic                   watchdog_timeout,
  input  logic                   irq_wake,
  input  logic                   core_sleep,
  input  logic                   global_interrupt_enable,
  input  rcss_pkg::rcss_cfg_t    cfg,
  input  rcss_pkg::rcss_bus_req_t bus_req,
  output logic [7:0]             reg_rdata,
  output logic                   core_reset,
  output logic                   wake_hold,
  output logic [7:0]             program_counter_low,
  output logic [7:0]             cpu_status_flags,
  output logic                   low_supply_flag_n
);

  logic [rcss_pkg::SYNC_N-1:0] sync1;
  logic [rcss_pkg::SYNC_N-1:0] sync2;
  logic [rcss_pkg::SYNC_N-1:0] sync3;
  logic [rcss_pkg::SYNC_N-1:0] stab;
  logic [rcss_pkg::SYNC_N-1:0] stab_q;
  logic                        por_s;
  logic                        lsv_s;
  logic                        master_clear_pin_n_stab;
  logic                        lf_rise;
  logic                        osc_rise;
  logic [rcss_pkg::FILT_W-1:0] master_clear_pin_n_cnt;
  logic                        master_clear_pin_n_filt;
  logic                        master_clear_pin_n_filt_q;
  logic                        master_clear_pin_n_onset;
  rcss_pkg::rcss_seq_t         state;
  logic                        settle_por;
  logic [rcss_pkg::CNT_W-1:0]  seq_cnt;
  logic                        xtal;
  logic                        settle_tick;
  logic [rcss_pkg::CNT_W-1:0]  settle_last;
  logic                        wdt_run;
  logic                        wake_ev;
  logic                        wdt_wake;
  logic                        irq_wk;
  logic [1:0]                  power_control_flags_hi;
  logic                        next_core_reset;
  logic                        next_wake_hold;
  logic [7:0]                  next_rdata;
  logic                        wr_pcl;
  logic                        wr_status;
  logic                        wr_power_control_flags;

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1  <= rcss_pkg::SYNC_RST;
      sync2  <= rcss_pkg::SYNC_RST;
      sync3  <= rcss_pkg::SYNC_RST;
      stab   <= rcss_pkg::SYNC_RST;
      stab_q <= rcss_pkg::SYNC_RST;
    end
    else
    begin
      sync1  <= {osc_input_pin, lfosc_clk_in, low_supply_trip, master_clear_pin_n, por_pulse};
      sync2  <= sync1;
      sync3  <= sync2;
      // a lane moves only when its second and third stages agree
      stab   <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & stab);
      stab_q <= stab;
    end
  end

  assign por_s     = stab[rcss_pkg::SI_POR];
  assign lsv_s     = stab[rcss_pkg::SI_LSV];
  assign master_clear_pin_n_stab = stab[rcss_pkg::SI_MASTER_CLEAR_PIN_N];
  assign lf_rise   = stab[rcss_pkg::SI_LF] & ~stab_q[rcss_pkg::SI_LF];
  assign osc_rise  = stab[rcss_pkg::SI_OSC] & ~stab_q[rcss_pkg::SI_OSC];

  // -----------------------------------------------------------------
  // master clear filter
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_clear_pin_n_cnt    <= rcss_pkg::FILT_ZERO;
      master_clear_pin_n_filt   <= 1'b0;
      master_clear_pin_n_filt_q <= 1'b0;
    end
    else
    begin
      master_clear_pin_n_filt_q <= master_clear_pin_n_filt;
      if (master_clear_pin_n_stab)
      begin
        master_clear_pin_n_cnt  <= rcss_pkg::FILT_ZERO;
        master_clear_pin_n_filt <= 1'b0;
      end
      else if (master_clear_pin_n_cnt == rcss_pkg::FILT_LAST)
        master_clear_pin_n_filt <= 1'b1;
      else
        master_clear_pin_n_cnt <= master_clear_pin_n_cnt + rcss_pkg::FILT_ONE;
    end
  end

  // -----------------------------------------------------------------
  // event classification
  // -----------------------------------------------------------------
  assign master_clear_pin_n_onset = master_clear_pin_n_filt & ~master_clear_pin_n_filt_q;
  assign xtal       = (cfg.osc_select_bit == rcss_pkg::OSC_XTAL);
  // watchdog reset acts only while awake and with neither por_s nor the filtered pin active
  assign wdt_run    = watchdog_timeout & ~core_sleep & ~por_s & ~master_clear_pin_n_filt;
  assign wake_ev    = core_sleep & (watchdog_timeout | irq_wake) & (state == rcss_pkg::SEQ_RUN)
                      & ~por_s & ~master_clear_pin_n_filt;
  assign wdt_wake   = wake_ev & watchdog_timeout;
  assign irq_wk     = wake_ev & ~watchdog_timeout;
  assign settle_tick = xtal ? osc_rise : 1'b1;
  assign settle_last = xtal ? rcss_pkg::OST_LAST : rcss_pkg::IN_LAST;

  // -----------------------------------------------------------------
  // start-up sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= rcss_pkg::SEQ_POR;
      settle_por <= 1'b1;
      seq_cnt    <= rcss_pkg::CNT_ZERO;
    end
    else if (por_s)
    begin
      state      <= rcss_pkg::SEQ_POR;
      settle_por <= 1'b1;
      seq_cnt    <= rcss_pkg::CNT_ZERO;
    end
    else
    begin
      case (state)
        rcss_pkg::SEQ_POR:
        begin
          seq_cnt    <= rcss_pkg::CNT_ZERO;
          settle_por <= 1'b1;
          if (!cfg.power_up_delay_enable_n)
            state <= rcss_pkg::SEQ_POWER_UP_DELAY_TIMER;
          else if (xtal)
            state <= rcss_pkg::SEQ_SETTLE;
          else
            state <= rcss_pkg::SEQ_RUN;
        end
        rcss_pkg::SEQ_POWER_UP_DELAY_TIMER:
        begin
          if (lf_rise)
          begin
            if (seq_cnt == rcss_pkg::POWER_UP_DELAY_TIMER_LAST)
            begin
              seq_cnt <= rcss_pkg::CNT_ZERO;
              state   <= rcss_pkg::SEQ_SETTLE;
            end
            else
              seq_cnt <= seq_cnt + rcss_pkg::CNT_ONE;
          end
        end
        rcss_pkg::SEQ_SETTLE:
        begin
          if (settle_tick)
          begin
            if (seq_cnt == settle_last)
            begin
              seq_cnt <= rcss_pkg::CNT_ZERO;
              state   <= rcss_pkg::SEQ_RUN;
            end
            else
              seq_cnt <= seq_cnt + rcss_pkg::CNT_ONE;
          end
        end
        rcss_pkg::SEQ_RUN:
        begin
          seq_cnt <= rcss_pkg::CNT_ZERO;
          if (wake_ev)
          begin
            state      <= rcss_pkg::SEQ_SETTLE;
            settle_por <= 1'b0;
          end
        end
        default:
        begin
          state   <= rcss_pkg::SEQ_POR;
          seq_cnt <= rcss_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // core reset and wake hold
  // -----------------------------------------------------------------
  always_comb
  begin
    next_core_reset = por_s | master_clear_pin_n_filt | wdt_run
                      | (state == rcss_pkg::SEQ_POR) | (state == rcss_pkg::SEQ_POWER_UP_DELAY_TIMER)
                      | ((state == rcss_pkg::SEQ_SETTLE) & settle_por);
    next_wake_hold  = (state == rcss_pkg::SEQ_SETTLE) & ~settle_por;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_reset <= 1'b1;
      wake_hold  <= 1'b0;
    end
    else
    begin
      core_reset <= next_core_reset;
      wake_hold  <= next_wake_hold;
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  assign wr_pcl    = bus_req.wr & (bus_req.addr == rcss_pkg::ADDR_PCL);
  assign wr_status = bus_req.wr & (bus_req.addr == rcss_pkg::ADDR_STATUS);
  assign wr_power_control_flags   = bus_req.wr & (bus_req.addr == rcss_pkg::ADDR_POWER_CONTROL_FLAGS);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      program_counter_low <= rcss_pkg::PC_RESET;
    else if (por_s | master_clear_pin_n_filt | wdt_run)
      program_counter_low <= rcss_pkg::PC_RESET;
    else if (irq_wk & global_interrupt_enable)
      program_counter_low <= rcss_pkg::PC_VECTOR;
    else if (wake_ev)
      program_counter_low <= program_counter_low + rcss_pkg::PC_STEP;
    else if (wr_pcl)
      program_counter_low <= bus_req.wdata;
  end

  // flags are read-only to software; events win over writes
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cpu_status_flags <= {rcss_pkg::ST_UP_POR, rcss_pkg::ST_LOW_RST};
    else if (por_s)
      cpu_status_flags[7:3] <= rcss_pkg::ST_UP_POR;
    else if (master_clear_pin_n_onset)
      cpu_status_flags[7:3] <= core_sleep ? rcss_pkg::ST_UP_MASTER_CLEAR_PIN_N_SLP : rcss_pkg::ST_UP_MASTER_CLEAR_PIN_N_RUN;
    else if (wdt_run)
      cpu_status_flags[7:3] <= rcss_pkg::ST_UP_WDT;
    else if (wdt_wake)
    begin
      cpu_status_flags[rcss_pkg::TO_BIT] <= 1'b0;
      cpu_status_flags[rcss_pkg::PD_BIT] <= 1'b0;
    end
    else if (irq_wk)
    begin
      cpu_status_flags[rcss_pkg::TO_BIT] <= 1'b1;
      cpu_status_flags[rcss_pkg::PD_BIT] <= 1'b0;
    end
    else if (wr_status)
    begin
      cpu_status_flags[7:5] <= bus_req.wdata[7:5];
      cpu_status_flags[2:0] <= bus_req.wdata[2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      power_control_flags_hi <= rcss_pkg::POWER_CONTROL_FLAGS_HI_POR;
    else if (por_s)
      power_control_flags_hi <= rcss_pkg::POWER_CONTROL_FLAGS_HI_POR;
    else if (wr_power_control_flags)
      power_control_flags_hi <= bus_req.wdata[2:1];
  end

  // low supply flag survives power-on, pin and watchdog resets, only rst_n loads it; the trip wins over a write
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      low_supply_flag_n <= rcss_pkg::LSF_RST;
    else if (lsv_s)
      low_supply_flag_n <= 1'b0;
    else if (wr_power_control_flags)
      low_supply_flag_n <= bus_req.wdata[rcss_pkg::LSF_BIT];
  end

  // -----------------------------------------------------------------
  // read port
  // -----------------------------------------------------------------
  always_comb
  begin
    case (bus_req.addr)
      rcss_pkg::ADDR_PCL:    next_rdata = program_counter_low;
      rcss_pkg::ADDR_STATUS: next_rdata = cpu_status_flags;
      rcss_pkg::ADDR_POWER_CONTROL_FLAGS:   next_rdata = {5'h00, power_control_flags_hi, low_supply_flag_n};
      default:               next_rdata = rcss_pkg::RDATA_NONE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= rcss_pkg::RDATA_NONE;
    else
      reg_rdata <= bus_req.rd ? next_rdata : rcss_pkg::RDATA_NONE;
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  AST_POR_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    por_s |=> cpu_status_flags[rcss_pkg::TO_BIT] && cpu_status_flags[rcss_pkg::PD_BIT] && core_reset)
    else $error("power-on did not set both flags");

  AST_WDT_RUN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wdt_run |=> !cpu_status_flags[rcss_pkg::TO_BIT] && cpu_status_flags[rcss_pkg::PD_BIT]
                && program_counter_low == rcss_pkg::PC_RESET && core_reset)
    else $error("watchdog reset values wrong");

  AST_WDT_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wdt_wake |=> !cpu_status_flags[rcss_pkg::TO_BIT] && !cpu_status_flags[rcss_pkg::PD_BIT]
                 && program_counter_low == $past(program_counter_low) + 8'h01 && !core_reset)
    else $error("watchdog wake handled as a reset");

  AST_IRQ_VECTOR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (irq_wk && global_interrupt_enable) |=> program_counter_low == rcss_pkg::PC_VECTOR
                                            && cpu_status_flags[rcss_pkg::TO_BIT])
    else $error("interrupt wake did not load the vector");

  AST_MASTER_CLEAR_PIN_N_GLITCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(master_clear_pin_n_stab) |-> !master_clear_pin_n_filt [*8])
    else $error("short master clear pulse passed the filter");

  AST_LOW_SUPPLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lsv_s |=> !low_supply_flag_n)
    else $error("low supply did not clear the flag");

  AST_OST_END: assert property (@(posedge clk_sys) disable iff (!rst_n || por_s)
    (state == rcss_pkg::SEQ_SETTLE && xtal && osc_rise && seq_cnt == rcss_pkg::OST_LAST)
    |=> state == rcss_pkg::SEQ_RUN)
    else $error("settle count did not end at 1024 edges");

  AST_IN_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_n || por_s)
    $rose(state == rcss_pkg::SEQ_SETTLE && !xtal)
    |-> (state == rcss_pkg::SEQ_SETTLE) [*8] ##1 (state == rcss_pkg::SEQ_RUN))
    else $error("internal oscillator delay not 8 cycles");

  AST_NO_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == rcss_pkg::SEQ_POR && !por_s && cfg.power_up_delay_enable_n && !xtal)
    |=> state == rcss_pkg::SEQ_RUN ##1 !core_reset)
    else $error("time-out added with delay disabled");

  AST_RESET_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (master_clear_pin_n_filt || state == rcss_pkg::SEQ_POWER_UP_DELAY_TIMER) |=> core_reset)
    else $error("core reset released while a source is active");

endmodule

//--- tb/rcss_pins_model.sv
// far-side model: master clear pin and the two oscillator sources
module rcss_pins_model (
  input  wire logic clk_sys,
  output logic      lfosc_clk_in,
  output logic      osc_input_pin,
  output logic      master_clear_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] div;

  initial
  begin
    div = 2'h0;
    lfosc_clk_in = 1'b0;
    osc_input_pin = 1'b1;
    master_clear_pin_n = 1'b1;
  end

  // free-running sources, period of four system cycles
  always @(posedge clk_sys)
  begin
    div <= div + 2'h1;
    lfosc_clk_in <= div[1];
    osc_input_pin <= ~div[1];
  end

  // pin pulled up; pressed low for n cycles
  task automatic press(input int n);
    @(posedge clk_sys);
    master_clear_pin_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    master_clear_pin_n <= 1'b1;
  endtask
endmodule

//--- tb/rcss_top_tb.sv
// self-checking bench of the reset cause and start-up sequencer
module rcss_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    clk_sys = 1'b0;
  logic                    rst_n;
  logic                    por_pulse;
  logic                    low_supply_trip;
  logic                    watchdog_timeout;
  logic                    irq_wake;
  logic                    core_sleep;
  logic                    global_interrupt_enable;
  rcss_pkg::rcss_cfg_t     cfg;
  rcss_pkg::rcss_bus_req_t bus_req;
  logic [7:0]              reg_rdata;
  logic                    core_reset;
  logic                    wake_hold;
  logic [7:0]              program_counter_low;
  logic [7:0]              cpu_status_flags;
  logic                    low_supply_flag_n;
  logic                    lfosc_clk_in;
  logic                    osc_input_pin;
  logic                    master_clear_pin_n;
  logic [7:0]              m_st;
  logic [7:0]              m_pc;
  logic [7:0]              d;
  int                      failures = 0;
  int                      num_checks = 0;
  int                      n;
  int                      exp_por[4] = '{13312, 9224, 4096, 0};

  always #2.5 clk_sys = ~clk_sys;

  rcss_top rcss_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .por_pulse(por_pulse),
    .master_clear_pin_n(master_clear_pin_n), .low_supply_trip(low_supply_trip),
    .lfosc_clk_in(lfosc_clk_in), .osc_input_pin(osc_input_pin), .watchdog_timeout(watchdog_timeout),
    .irq_wake(irq_wake), .core_sleep(core_sleep), .global_interrupt_enable(global_interrupt_enable),
    .cfg(cfg), .bus_req(bus_req), .reg_rdata(reg_rdata), .core_reset(core_reset), .wake_hold(wake_hold),
    .program_counter_low(program_counter_low), .cpu_status_flags(cpu_status_flags),
    .low_supply_flag_n(low_supply_flag_n));

  rcss_pins_model rcss_pins_model_inst (.clk_sys(clk_sys), .lfosc_clk_in(lfosc_clk_in),
    .osc_input_pin(osc_input_pin), .master_clear_pin_n(master_clear_pin_n));

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic chk_regs(input string what);
    logic [7:0] v;
    rd(rcss_pkg::ADDR_STATUS, v);
    chk({what, " status"}, v, m_st);
    chk({what, " status port"}, cpu_status_flags, m_st);
    rd(rcss_pkg::ADDR_PCL, v);
    chk({what, " pc"}, v, m_pc);
    chk({what, " pc port"}, program_counter_low, m_pc);
  endtask

  // cycles until the core leaves reset, bounded
  task automatic wait_run(output int c);
    c = 0;
    while (core_reset !== 1'b0 && c < 20000)
    begin
      @(posedge clk_sys);
      #1 c++;
    end
  endtask

  // one-cycle wake pulse while asleep, then count stalled cycles
  task automatic wake(input bit irq, output int c);
    @(posedge clk_sys);
    core_sleep <= 1'b1;
    @(posedge clk_sys);
    if (irq)
      irq_wake <= 1'b1;
    else
      watchdog_timeout <= 1'b1;
    @(posedge clk_sys);
    irq_wake <= 1'b0;
    watchdog_timeout <= 1'b0;
    core_sleep <= 1'b0;
    c = 0;
    repeat (20)
    begin
      @(posedge clk_sys);
      #1 c += int'(wake_hold === 1'b1);
    end
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    por_pulse = 1'b1;
    low_supply_trip = 1'b0;
    watchdog_timeout = 1'b0;
    irq_wake = 1'b0;
    core_sleep = 1'b0;
    global_interrupt_enable = 1'b0;
    cfg = 2'h3;
    bus_req = '0;
    void'($urandom(28117));
    m_st = 8'h18;
    m_pc = 8'h00;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3)
    begin
      @(posedge clk_sys);
      #1 chk("reset after release", {7'h0, core_reset}, 8'h01);
    end
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      cfg <= rcss_pkg::rcss_cfg_t'(2'(i));
      por_pulse <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk("reset during por", {7'h0, core_reset}, 8'h01);
      por_pulse <= 1'b0;
      wait_run(n);
      chk("start-up length", {7'h0, n >= exp_por[i] - 4 && n <= exp_por[i] + 20}, 8'h01);
      m_st = {5'b00011, m_st[2:0]};
      m_pc = 8'h00;
      chk_regs("por");
      rd(rcss_pkg::ADDR_POWER_CONTROL_FLAGS, d);
      chk("power_control_flags after por", d & 8'hfe, 8'h00);
    end
    m_pc = 8'($urandom);
    wr(rcss_pkg::ADDR_PCL, m_pc);
    wr(rcss_pkg::ADDR_STATUS, 8'hff);
    m_st = {3'b111, m_st[4:3], 3'b111};
    chk_regs("write");
    rd(8'h7f, d);
    chk("unmapped", d, 8'h00);
    wr(rcss_pkg::ADDR_POWER_CONTROL_FLAGS, 8'h01);
    rd(rcss_pkg::ADDR_POWER_CONTROL_FLAGS, d);
    chk("power_control_flags set", d, 8'h01);
    @(posedge clk_sys);
    #1 chk("read data idle", reg_rdata, 8'h00);
    @(posedge clk_sys);
    low_supply_trip <= 1'b1;
    repeat (8) @(posedge clk_sys);
    low_supply_trip <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(rcss_pkg::ADDR_POWER_CONTROL_FLAGS, d);
    chk("power_control_flags trip", d, 8'h00);
    chk("low supply port", {7'h0, low_supply_flag_n}, 8'h00);
    wr(rcss_pkg::ADDR_PCL, 8'($urandom));
    @(posedge clk_sys);
    watchdog_timeout <= 1'b1;
    @(posedge clk_sys);
    watchdog_timeout <= 1'b0;
    #1 chk("wdt reset", {7'h0, core_reset}, 8'h01);
    wait_run(n);
    m_st = {5'b00001, m_st[2:0]};
    m_pc = 8'h00;
    chk_regs("wdt run");
    rcss_pins_model_inst.press(1 + int'($urandom % 12));
    repeat (30) @(posedge clk_sys);
    #1 chk("glitch", {7'h0, core_reset}, 8'h00);
    chk_regs("glitch");
    wr(rcss_pkg::ADDR_PCL, 8'($urandom));
    wr(rcss_pkg::ADDR_STATUS, 8'he5);
    wr(rcss_pkg::ADDR_POWER_CONTROL_FLAGS, 8'h07);
    rcss_pins_model_inst.press(40);
    wait_run(n);
    m_st = {5'b00011, 3'b101};
    chk_regs("master_clear_pin_n run");
    wr(rcss_pkg::ADDR_STATUS, 8'he5);
    core_sleep <= 1'b1;
    rcss_pins_model_inst.press(40);
    core_sleep <= 1'b0;
    wait_run(n);
    m_st = {5'b00010, 3'b101};
    chk_regs("master_clear_pin_n sleep");
    rd(rcss_pkg::ADDR_POWER_CONTROL_FLAGS, d);
    chk("power_control_flags kept", d, 8'h07);
    for (int k = 0; k < 3; k++)
    begin
      wr(rcss_pkg::ADDR_STATUS, 8'hff);
      m_pc = 8'($urandom) & 8'hf0;
      wr(rcss_pkg::ADDR_PCL, m_pc);
      global_interrupt_enable <= (k == 1);
      wake(k != 0, n);
      chk("wake stall", {7'h0, n >= 8 && n <= 9}, 8'h01);
      chk("no reset on wake", {7'h0, core_reset}, 8'h00);
      m_st = {3'b111, k != 0, 1'b0, 3'b111};
      m_pc = (k == 1) ? 8'h04 : m_pc + 8'h01;
      chk_regs("wake");
    end
    summarize();
  end

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    summarize();
  end
endmodule
